/* rtl/wdclr_consts.svh */
// Constants for the watchdog-clear instruction decoder
`ifndef WDCLR_CONSTS_SVH
`define WDCLR_CONSTS_SVH
`define WDCLR_OPCODE 14'h0064
`define WDCLR_OPCODE_W 14
`define WDCLR_WDT_W 8
`define WDCLR_PRE_W 8
`define WDCLR_WDT_CLEAR 8'h00
`define WDCLR_PRE_CLEAR 8'h00
`define WDCLR_FLAG_SET 1'b1
`define WDCLR_FLAG_RST 1'b1
`endif

/* rtl/wdclr_pkg.sv */
// Types for the watchdog-clear instruction decoder
package wdclr_pkg;
   typedef enum logic [1:0] {
      WDCLR_Q1 = 2'b00,
      WDCLR_Q2 = 2'b01,
      WDCLR_Q3 = 2'b10,
      WDCLR_Q4 = 2'b11
   } wdclr_phase_e;
endpackage

/* rtl/wdclr_match.sv */
// Opcode comparator for the watchdog-clear instruction
`timescale 1ns/10ps
`include "wdclr_consts.svh"
module wdclr_match #(
   parameter int OPW = `WDCLR_OPCODE_W
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Instruction word and its valid strobe
   input wire logic [OPW-1:0] i_instr,
   input wire logic i_load,
   // Registered decode result
   output logic o_hit
);
   logic hit_reg;
   logic hit_next;

   // Whole-word compare, no operand fields to mask
   always_comb begin
      hit_next = hit_reg;
      if (i_load) begin
         hit_next = (i_instr == OPW'(`WDCLR_OPCODE));
      end
   end

   // Decode result held until the next load
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         hit_reg <= 1'b0;
      end else begin
         hit_reg <= hit_next;
      end
   end

   assign o_hit = hit_reg;
endmodule

/* rtl/wdclr_exec.sv */
// Watchdog-clear instruction decode and execute
`timescale 1ns/10ps
`include "wdclr_consts.svh"
module wdclr_exec
   import wdclr_pkg::*;
#(
   parameter int OPW = `WDCLR_OPCODE_W
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Instruction register from the core, valid at the decode phase
   input wire logic [OPW-1:0] i_instr,
   input wire logic i_instr_valid,
   // Four-phase pacing
   output logic [1:0] o_phase,
   // Watchdog side actions, one-cycle pulses
   output logic o_wdt_clear,
   output logic o_pre_clear,
   output logic o_flag_set,
   // Values written on a clear
   output logic [`WDCLR_WDT_W-1:0] o_wdt_value,
   output logic [`WDCLR_PRE_W-1:0] o_pre_value,
   output logic o_timeout_flag_n,
   output logic o_powerdown_flag_n
);
   wdclr_phase_e phase_reg;
   wdclr_phase_e phase_next;
   logic load;
   logic hit;
   logic clr_reg;
   logic clr_next;
   logic [1:0] phase_q;
   logic taken_reg;
   logic taken_next;
   logic [`WDCLR_WDT_W-1:0] wdt_value_reg;
   logic [`WDCLR_WDT_W-1:0] wdt_value_next;
   logic [`WDCLR_PRE_W-1:0] pre_value_reg;
   logic [`WDCLR_PRE_W-1:0] pre_value_next;
   logic to_n_reg;
   logic to_n_next;
   logic pd_n_reg;
   logic pd_n_next;

   // Word captured only in the decode phase
   assign load = (phase_reg == WDCLR_Q1) && i_instr_valid;

   wdclr_match #(
      .OPW(OPW)
   ) u_match (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_instr(i_instr),
      .i_load(load),
      .o_hit(hit)
   );

   // Phase counter, free running through Q1..Q4
   always_comb begin
      unique case (phase_reg)
         WDCLR_Q1: phase_next = WDCLR_Q2;
         WDCLR_Q2: phase_next = WDCLR_Q3;
         WDCLR_Q3: phase_next = WDCLR_Q4;
         WDCLR_Q4: phase_next = WDCLR_Q1;
      endcase
      // Valid caught with the word, so an idle decode phase cannot reuse an old match
      taken_next = taken_reg;
      if (phase_reg == WDCLR_Q1) begin
         taken_next = i_instr_valid;
      end
      // Clear fires while entering Q4, so it is seen in Q4
      clr_next = (phase_reg == WDCLR_Q3) && hit && taken_reg;
   end

   // State registers
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         phase_reg <= WDCLR_Q1;
         clr_reg <= 1'b0;
         phase_q <= 2'b00;
         taken_reg <= 1'b0;
      end else begin
         phase_reg <= phase_next;
         clr_reg <= clr_next;
         phase_q <= phase_next;
         taken_reg <= taken_next;
      end
   end

   // All actions share one pulse so counter, prescaler and flags move together
   assign o_phase = phase_q;
   assign o_wdt_clear = clr_reg;
   assign o_pre_clear = clr_reg;
   assign o_flag_set = clr_reg;
   assign o_wdt_value = wdt_value_reg;
   assign o_pre_value = pre_value_reg;
   // Only the strobe tells the status register to write these
   assign o_timeout_flag_n = to_n_reg;
   assign o_powerdown_flag_n = pd_n_reg;

   // Fixed values, kept in flops so that every output leaves a register
   always_comb begin
      wdt_value_next = `WDCLR_WDT_CLEAR;
      pre_value_next = `WDCLR_PRE_CLEAR;
      to_n_next = `WDCLR_FLAG_SET;
      pd_n_next = `WDCLR_FLAG_SET;
   end

   // Reset loads the written values too, so a clear just after reset is safe
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wdt_value_reg <= `WDCLR_WDT_CLEAR;
         pre_value_reg <= `WDCLR_PRE_CLEAR;
         to_n_reg <= `WDCLR_FLAG_RST;
         pd_n_reg <= `WDCLR_FLAG_RST;
      end else begin
         wdt_value_reg <= wdt_value_next;
         pre_value_reg <= pre_value_next;
         to_n_reg <= to_n_next;
         pd_n_reg <= pd_n_next;
      end
   end

   // Checks on what the watchdog side acts on
   sequence s_decode_hit;
      phase_reg == WDCLR_Q1 && i_instr_valid && i_instr == OPW'(`WDCLR_OPCODE);
   endsequence

   property p_clear_in_q4;
      @(posedge i_clk) disable iff (i_rst)
      s_decode_hit |-> ##3 (o_wdt_clear && o_phase == 2'b11);
   endproperty
   a_clear_in_q4: assert property (p_clear_in_q4) else $error("clear missed Q4");

   property p_no_false_clear;
      @(posedge i_clk) disable iff (i_rst)
      (phase_reg == WDCLR_Q1 && !(i_instr_valid && i_instr == OPW'(`WDCLR_OPCODE)))
         |-> ##3 !o_wdt_clear;
   endproperty
   a_no_false_clear: assert property (p_no_false_clear) else $error("spurious clear");

   property p_pre_with_wdt;
      @(posedge i_clk) disable iff (i_rst)
      o_wdt_clear |-> (o_pre_clear && o_wdt_value == 8'h00 && o_pre_value == 8'h00);
   endproperty
   a_pre_with_wdt: assert property (p_pre_with_wdt) else $error("prescaler not cleared");

   property p_flags_set;
      @(posedge i_clk) disable iff (i_rst)
      o_flag_set |-> (o_timeout_flag_n && o_powerdown_flag_n && o_wdt_clear);
   endproperty
   a_flags_set: assert property (p_flags_set) else $error("flags not set");

   property p_single_pulse;
      @(posedge i_clk) disable iff (i_rst)
      o_wdt_clear |=> !o_wdt_clear [*3];
   endproperty
   a_single_pulse: assert property (p_single_pulse) else $error("clear not single");

   // Steps of one instruction cycle for the phase walk, and the decode-phase miss for the side-write check
   sequence s_in_q2;
      o_phase == 2'b01;
   endsequence

   sequence s_in_q3;
      o_phase == 2'b10;
   endsequence

   sequence s_in_q4;
      o_phase == 2'b11;
   endsequence

   sequence s_decode_miss;
      phase_reg == WDCLR_Q1 && !(i_instr_valid && i_instr == OPW'(`WDCLR_OPCODE));
   endsequence

   // Phase walks Q1 to Q4 and back without a skip
   property p_phase_walk;
      @(posedge i_clk) disable iff (i_rst)
      o_phase == 2'b00 |=> s_in_q2 ##1 s_in_q3 ##1 s_in_q4 ##1 o_phase == 2'b00;
   endproperty
   a_phase_walk: assert property (p_phase_walk) else $error("phase walk broken");

   // Clear only ever shows in the fourth phase
   property p_clear_only_q4;
      @(posedge i_clk) disable iff (i_rst)
      o_wdt_clear |-> s_in_q4;
   endproperty
   a_clear_only_q4: assert property (p_clear_only_q4) else $error("clear off Q4");

   // Next instruction starts right after the clear, one word per cycle
   property p_phase_after_clear;
      @(posedge i_clk) disable iff (i_rst)
      o_wdt_clear |=> o_phase == 2'b00;
   endproperty
   a_phase_after_clear: assert property (p_phase_after_clear) else $error("cycle overrun");

   // A missed or unqualified word leaves prescaler and flags alone
   property p_no_false_side;
      @(posedge i_clk) disable iff (i_rst)
      s_decode_miss |-> ##3 (!o_pre_clear && !o_flag_set);
   endproperty
   a_no_false_side: assert property (p_no_false_side) else $error("stray side write");

   // Quiet through Q2 and Q3, then prescaler and flags together
   property p_quiet_until_q4;
      @(posedge i_clk) disable iff (i_rst)
      s_decode_hit |-> ##1 !o_wdt_clear ##1 !o_wdt_clear ##1 (o_pre_clear && o_flag_set);
   endproperty
   a_quiet_until_q4: assert property (p_quiet_until_q4) else $error("clear out of step");

   // Qualifier follows the valid strobe of each decode phase
   property p_taken_tracks;
      @(posedge i_clk) disable iff (i_rst)
      phase_reg == WDCLR_Q1 |=> taken_reg == $past(i_instr_valid);
   endproperty
   a_taken_tracks: assert property (p_taken_tracks) else $error("qualifier lost");

   // Written values never drift from zero counts and set flags
   property p_outputs_fixed;
      @(posedge i_clk) disable iff (i_rst)
      o_wdt_value == 8'h00 && o_pre_value == 8'h00 && o_timeout_flag_n && o_powerdown_flag_n;
   endproperty
   a_outputs_fixed: assert property (p_outputs_fixed) else $error("values drifted");
endmodule

/* verification/wdclr_wdt_model.sv */
// Watchdog counter, prescaler and status flags fed by the decoder
`timescale 1ns/10ps
module wdclr_wdt_model (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Strobes and values from the decoder
   input wire logic i_clr,
   input wire logic i_pclr,
   input wire logic i_fset,
   input wire logic [7:0] i_wdt,
   input wire logic [7:0] i_pre,
   input wire logic i_to_n,
   input wire logic i_pd_n,
   // Observed state
   output logic [7:0] o_wdt,
   output logic [7:0] o_pre,
   output logic [1:0] o_flags
);
   // Counts run free so a missed clear shows as a nonzero value
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_wdt <= 8'h5A;
         o_pre <= 8'hA5;
         o_flags <= 2'h0; // Cleared so a flag write is visible
      end else begin
         o_wdt <= i_clr ? i_wdt : o_wdt + 8'h01;
         o_pre <= i_pclr ? i_pre : o_pre + 8'h03;
         o_flags <= i_fset ? {i_to_n, i_pd_n} : o_flags;
      end
   end
endmodule

/* verification/watchdog_clear_instruction_tb_top.sv */
// Bench for the watchdog-clear decoder with its watchdog model
`timescale 1ns/10ps
module watchdog_clear_instruction_tb_top;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [13:0] i_instr = 14'h0000;
   logic i_instr_valid = 1'b0;
   logic [1:0] o_phase, flags;
   logic o_wdt_clear, o_pre_clear, o_flag_set, to_n, pd_n;
   logic [7:0] wdt_v, pre_v, wdt, pre;
   int errors = 0;
   int total_checks = 0;
   always #5 i_clk = ~i_clk;
   wdclr_exec dut (.i_clk(i_clk), .i_rst(i_rst), .i_instr(i_instr),
      .i_instr_valid(i_instr_valid), .o_phase(o_phase), .o_wdt_clear(o_wdt_clear),
      .o_pre_clear(o_pre_clear), .o_flag_set(o_flag_set), .o_wdt_value(wdt_v),
      .o_pre_value(pre_v), .o_timeout_flag_n(to_n), .o_powerdown_flag_n(pd_n));
   wdclr_wdt_model wdm (.i_clk(i_clk), .i_rst(i_rst), .i_clr(o_wdt_clear),
      .i_pclr(o_pre_clear), .i_fset(o_flag_set), .i_wdt(wdt_v), .i_pre(pre_v),
      .i_to_n(to_n), .i_pd_n(pd_n), .o_wdt(wdt), .o_pre(pre), .o_flags(flags));
   task automatic chk(input string what, input logic [17:0] seen, input logic [17:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One instruction slot; the clear word is offered again outside decode
   task automatic run(input logic [13:0] op, input logic v, input logic hit);
      while (o_phase !== 2'h0) @(posedge i_clk) #1;
      i_instr = op;
      i_instr_valid = v;
      @(posedge i_clk) #1;
      i_instr = 14'h0064;
      repeat (2) begin
         chk("early", {o_wdt_clear, o_pre_clear, o_flag_set}, 18'h0);
         @(posedge i_clk) #1;
      end
      i_instr_valid = 1'b0;
      chk("q4", {o_phase, o_wdt_clear, o_pre_clear, o_flag_set}, {2'h3, {3{hit}}});
      @(posedge i_clk) #1;
      if (hit) chk("state", {wdt, pre, flags}, 18'h00003);
      else chk("untouched", {wdt == 8'h00, pre == 8'h00}, 18'h0);
   endtask
   // Reset lands inside an instruction; nothing may fire and the phase restarts at Q1
   task automatic reset_mid();
      while (o_phase !== 2'h0) @(posedge i_clk) #1;
      i_instr = 14'h0064;
      i_instr_valid = 1'b1;
      @(posedge i_clk) #1;
      i_instr_valid = 1'b0;
      i_rst = 1'b1;
      #1 chk("in reset", {o_phase, o_wdt_clear, o_pre_clear, o_flag_set}, 18'h0);
      @(posedge i_clk) #1;
      i_rst = 1'b0;
      repeat (4) begin
         chk("after reset", {o_wdt_clear, o_pre_clear, o_flag_set}, 18'h0);
         @(posedge i_clk) #1;
      end
      chk("restart", o_phase, 18'h0);
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Main sequence: back-to-back clears, unqualified word, one-bit neighbours, reset
   initial begin
      repeat (3) @(posedge i_clk);
      #1 i_rst = 1'b0;
      run(14'h0064, 1'b1, 1'b1);
      run(14'h0064, 1'b1, 1'b1);
      run(14'h0064, 1'b0, 1'b0);
      for (int i = 0; i < 14; i++) run(14'h0064 ^ (14'h0001 << i), 1'b1, 1'b0);
      reset_mid();
      run(14'h0064, 1'b1, 1'b1);
      wrap_up();
   end
   // Whole run needs about 0.8 us
   initial begin
      #5000;
      errors++;
      wrap_up();
   end
endmodule
